/* design/swd_pkg.sv */
// swd_pkg: register indices, field layout, reset values and carrier types
// for the sync-word matcher and signal-strength readout.
// assumes a 32-bit classic wishbone bus with one register per aligned word.
package swd_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register indices; byte address is four times the index
	localparam logic [7:0] SWD_IDX_CONTROL = 8'h12;
	localparam logic [7:0] SWD_IDX_RESERVED = 8'h13;
	localparam logic [7:0] SWD_IDX_STRENGTH = 8'h14;
	localparam logic [7:0] SWD_IDX_PATTERN0 = 8'h16;
	localparam logic [7:0] SWD_IDX_PATTERN1 = 8'h17;
	localparam logic [7:0] SWD_IDX_PATTERN2 = 8'h18;
	localparam logic [7:0] SWD_IDX_PATTERN3 = 8'h19;

	////////////////////////////////////////////////////////////////////////////////
	// sync_match_control field positions
	localparam int SWD_POS_ENABLE = 5;
	localparam int SWD_POS_LENGTH = 3;
	localparam int SWD_POS_TOL = 1;

	////////////////////////////////////////////////////////////////////////////////
	// values after reset
	localparam logic SWD_RST_ENABLE = 1'b0;
	localparam logic [1:0] SWD_RST_LENGTH = 2'h3;
	localparam logic [1:0] SWD_RST_TOL = 2'h0;
	localparam logic [7:0] SWD_RST_RESERVED = 8'h07;
	localparam logic [31:0] SWD_RST_PATTERN = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////////////
	// length codes
	localparam logic [1:0] SWD_LEN_8 = 2'h0;
	localparam logic [1:0] SWD_LEN_16 = 2'h1;
	localparam logic [1:0] SWD_LEN_24 = 2'h2;
	localparam logic [1:0] SWD_LEN_32 = 2'h3;

	// answer to an unmapped address
	localparam logic [31:0] SWD_UNMAPPED_DATA = 32'h0000_0000;

	typedef struct packed {
		logic pattern_recognition_enable;
		logic [1:0] pattern_length_select;
		logic [1:0] pattern_error_tolerance;
	} swd_ctrl_t;

	typedef struct packed {
		logic [7:0] adr_idx;
		logic we;
		logic [3:0] sel;
		logic [31:0] dat;
	} swd_req_t;

endpackage : swd_pkg

/* design/swd_sync_detect.sv */
// swd_sync_detect: sync-word recognition with error tolerance, plus the
// signal-strength status register, behind a classic wishbone slave.
// assumes rx bits and the strength measurement come from logic on ref_clk.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
module swd_sync_detect #(
	parameter int ADR_W = 8
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// demodulated bit stream
	input wire logic rx_bit,
	input wire logic rx_bit_valid,
	// strength measurement, 0.5 dB per count
	input wire logic [7:0] rssi_in,
	// recognition result
	output logic sync_found
);
	import swd_pkg::*;

	// index field is eight bits wide, so a wider bus would alias registers
	if (ADR_W < 7 || ADR_W > 10) begin : g_bad_adr
		$error("ADR_W must be 7..10 to reach all registers");
	end

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [5:0] swd_len_bits(input logic [1:0] code);
		case (code)
			SWD_LEN_8: swd_len_bits = 6'd8;
			SWD_LEN_16: swd_len_bits = 6'd16;
			SWD_LEN_24: swd_len_bits = 6'd24;
			default: swd_len_bits = 6'd32;
		endcase
	endfunction : swd_len_bits

	// first pattern byte is oldest: top bits line up with the oldest received bit
	function automatic logic [31:0] swd_aligned(input logic [31:0] pat, input logic [1:0] code);
		case (code)
			SWD_LEN_8: swd_aligned = {24'h00_0000, pat[31:24]};
			SWD_LEN_16: swd_aligned = {16'h0000, pat[31:16]};
			SWD_LEN_24: swd_aligned = {8'h00, pat[31:8]};
			default: swd_aligned = pat;
		endcase
	endfunction : swd_aligned

	function automatic logic [31:0] swd_mask(input logic [1:0] code);
		case (code)
			SWD_LEN_8: swd_mask = 32'h0000_00FF;
			SWD_LEN_16: swd_mask = 32'h0000_FFFF;
			SWD_LEN_24: swd_mask = 32'h00FF_FFFF;
			default: swd_mask = 32'hFFFF_FFFF;
		endcase
	endfunction : swd_mask

	function automatic logic [5:0] swd_popcount(input logic [31:0] v);
		logic [5:0] n;
		n = 6'd0;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'd0, v[i]};
		end
		swd_popcount = n;
	endfunction : swd_popcount

	////////////////////////////////////////////////////////////////////////////////
	// bus request decode

	swd_req_t req;
	logic bus_take;
	logic bus_write;

	assign req.adr_idx = 8'(wb_adr_i[ADR_W-1:2]);
	assign req.we = wb_we_i;
	assign req.sel = wb_sel_i;
	assign req.dat = wb_dat_i;
	// taken once per request; ack in the next cycle ends it
	assign bus_take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	// registers are one byte wide, so only lane 0 carries a write
	assign bus_write = bus_take && req.we && req.sel[0];

	////////////////////////////////////////////////////////////////////////////////
	// registers

	swd_ctrl_t ctrl;
	logic [7:0] reserved_config;
	logic [7:0] signal_strength_value;
	logic [31:0] pattern_value_bytes;

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl.pattern_recognition_enable <= SWD_RST_ENABLE;
			ctrl.pattern_length_select <= SWD_RST_LENGTH;
			ctrl.pattern_error_tolerance <= SWD_RST_TOL;
		end else if (bus_write && req.adr_idx == SWD_IDX_CONTROL) begin
			ctrl.pattern_recognition_enable <= req.dat[SWD_POS_ENABLE];
			ctrl.pattern_length_select <= req.dat[SWD_POS_LENGTH +: 2];
			ctrl.pattern_error_tolerance <= req.dat[SWD_POS_TOL +: 2];
		end
	end

	// stored so a read returns what was written; nothing else looks at it
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			reserved_config <= SWD_RST_RESERVED;
		end else if (bus_write && req.adr_idx == SWD_IDX_RESERVED) begin
			reserved_config <= req.dat[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pattern_value_bytes <= SWD_RST_PATTERN;
		end else if (bus_write) begin
			case (req.adr_idx)
				SWD_IDX_PATTERN0: pattern_value_bytes[31:24] <= req.dat[7:0];
				SWD_IDX_PATTERN1: pattern_value_bytes[23:16] <= req.dat[7:0];
				SWD_IDX_PATTERN2: pattern_value_bytes[15:8] <= req.dat[7:0];
				SWD_IDX_PATTERN3: pattern_value_bytes[7:0] <= req.dat[7:0];
				default: pattern_value_bytes <= pattern_value_bytes;
			endcase
		end
	end

	// no reset and no bus write path: a live copy of the measurement
	always_ff @(posedge ref_clk) begin
		signal_strength_value <= rssi_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	// matcher

	logic [31:0] rx_shift;
	logic [31:0] next_rx_shift;
	logic [5:0] rx_fill;
	logic [5:0] err_now;
	logic window_full;
	logic match_now;

	assign next_rx_shift = {rx_shift[30:0], rx_bit};
	assign err_now = swd_popcount((next_rx_shift
		^ swd_aligned(pattern_value_bytes, ctrl.pattern_length_select))
		& swd_mask(ctrl.pattern_length_select));
	// a partly filled window could match on stale bits
	assign window_full = (rx_fill + 6'd1) >= swd_len_bits(ctrl.pattern_length_select);
	assign match_now = ctrl.pattern_recognition_enable && rx_bit_valid && window_full
		&& err_now <= {4'd0, ctrl.pattern_error_tolerance};

	always_ff @(posedge ref_clk) begin
		if (sys_rst || !ctrl.pattern_recognition_enable) begin
			rx_shift <= 32'h0000_0000;
			rx_fill <= 6'd0;
		end else if (rx_bit_valid) begin
			rx_shift <= next_rx_shift;
			rx_fill <= (rx_fill == 6'd32) ? rx_fill : rx_fill + 6'd1;
		end
	end

	// one-cycle pulse per accepted bit position
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_found <= 1'b0;
		end else begin
			sync_found <= match_now;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bus answer: one wait-free cycle, ack in the cycle after the request

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= bus_take;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (bus_take && !req.we) begin
			case (req.adr_idx)
				SWD_IDX_CONTROL: wb_dat_o <= {26'h000_0000,
					ctrl.pattern_recognition_enable, ctrl.pattern_length_select,
					ctrl.pattern_error_tolerance, 1'b0};
				SWD_IDX_RESERVED: wb_dat_o <= {24'h00_0000, reserved_config};
				SWD_IDX_STRENGTH: wb_dat_o <= {24'h00_0000, signal_strength_value};
				SWD_IDX_PATTERN0: wb_dat_o <= {24'h00_0000, pattern_value_bytes[31:24]};
				SWD_IDX_PATTERN1: wb_dat_o <= {24'h00_0000, pattern_value_bytes[23:16]};
				SWD_IDX_PATTERN2: wb_dat_o <= {24'h00_0000, pattern_value_bytes[15:8]};
				SWD_IDX_PATTERN3: wb_dat_o <= {24'h00_0000, pattern_value_bytes[7:0]};
				default: wb_dat_o <= SWD_UNMAPPED_DATA;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_match_needs_enable: assert property (@(posedge ref_clk) disable iff (sys_rst)
		sync_found |-> $past(ctrl.pattern_recognition_enable))
		else $error("match reported while recognition disabled");

	chk_enable_after_reset: assert property (@(posedge ref_clk)
		$past(sys_rst) |-> !ctrl.pattern_recognition_enable && sync_found == 1'b0)
		else $error("recognition enabled straight after reset");

	chk_length_reset: assert property (@(posedge ref_clk)
		$past(sys_rst) |-> ctrl.pattern_length_select == SWD_LEN_32)
		else $error("length field not 32 bits after reset");

	chk_length_window: assert property (@(posedge ref_clk) disable iff (sys_rst)
		sync_found |-> $past(rx_fill) + 6'd1 >= swd_len_bits($past(ctrl.pattern_length_select)))
		else $error("match reported before window filled");

	chk_tolerance_accept: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(ctrl.pattern_recognition_enable && rx_bit_valid && window_full
		&& err_now <= {4'd0, ctrl.pattern_error_tolerance}) |=> sync_found)
		else $error("match within tolerance not reported");

	chk_tolerance_reject: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(err_now > {4'd0, ctrl.pattern_error_tolerance}) |=> !sync_found)
		else $error("match reported beyond tolerance");

	chk_reserved_reset: assert property (@(posedge ref_clk)
		$past(sys_rst) |-> reserved_config == SWD_RST_RESERVED)
		else $error("reserved register not 0x07 after reset");

	chk_strength_follow: assert property (@(posedge ref_clk)
		##1 signal_strength_value == $past(rssi_in))
		else $error("strength register not following measurement");

	chk_strength_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(bus_take && !req.we && req.adr_idx == SWD_IDX_STRENGTH)
		|=> wb_ack_o && wb_dat_o == {24'h00_0000, $past(signal_strength_value)})
		else $error("strength read returned wrong value");

	chk_ack_single: assert property (@(posedge ref_clk) disable iff (sys_rst)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	// independent reference: left-aligns the window instead of right-aligning the pattern
	logic [5:0] ref_len;
	logic [31:0] ref_diff;
	logic ref_armed;
	logic [5:0] ref_fill;

	assign ref_len = 6'd8 + {1'b0, ctrl.pattern_length_select, 3'd0};
	assign ref_diff = ((next_rx_shift << (6'd32 - ref_len)) ^ pattern_value_bytes)
		& ~(32'hFFFF_FFFF >> ref_len);
	assign ref_armed = ctrl.pattern_recognition_enable && rx_bit_valid
		&& ref_fill >= ref_len - 6'd1;

	// own fill count, so the reference checks do not trust rx_fill
	always_ff @(posedge ref_clk) begin
		if (sys_rst || !ctrl.pattern_recognition_enable) begin
			ref_fill <= 6'd0;
		end else if (rx_bit_valid && ref_fill != 6'd32) begin
			ref_fill <= ref_fill + 6'd1;
		end
	end

	chk_reference_accept: assert property (@(posedge ref_clk) disable iff (sys_rst)
		ref_armed && $countones(ref_diff) <= int'(ctrl.pattern_error_tolerance) |=> sync_found)
		else $error("reference match within tolerance not reported");

	chk_reference_refuse: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(ref_armed && $countones(ref_diff) <= int'(ctrl.pattern_error_tolerance))
		|=> !sync_found)
		else $error("pulse reported without a reference match");

	chk_control_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(bus_write && req.adr_idx == SWD_IDX_CONTROL) |=> $stable(ctrl))
		else $error("control field changed without a write");

	chk_reserved_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!(bus_write && req.adr_idx == SWD_IDX_RESERVED) |=> $stable(reserved_config))
		else $error("reserved register changed without a write");

	chk_window_cleared: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!ctrl.pattern_recognition_enable |=> rx_fill == 6'd0 && rx_shift == 32'h0000_0000)
		else $error("window kept bits while recognition disabled");

endmodule : swd_sync_detect

/* test/swd_testbench.sv */
// testbench: register-level tests of the sync-word matcher and strength readout.
// assumes swd_sync_detect with default ADR_W and the classic wishbone timing of its notes.
`timescale 1ns/1ps
module testbench;
	import swd_pkg::*;

	`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; \
		$display("[ERR] %0t got %h exp %h", $time, a, b); end end

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [31:0] PAT = 32'hA5C3_5A96;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic rx_bit = 1'b0;
	logic rx_bit_valid = 1'b0;
	logic [7:0] rssi_in = 8'h00;
	logic sync_found;
	int n_fail = 0;
	int n_checks = 0;
	int n_found = 0;
	logic [31:0] rd;

	swd_sync_detect dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_bit(rx_bit),
		.rx_bit_valid(rx_bit_valid), .rssi_in(rssi_in), .sync_found(sync_found));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	// pulses counted rather than timed, so latency choices do not matter
	always @(posedge ref_clk) begin
		if (sync_found === 1'b1) n_found++;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic acc(input logic we, input logic [7:0] idx, input logic [7:0] wd);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= {idx[5:0], 2'b00};
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h00_0000, wd};
		do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		@(posedge ref_clk);
	endtask : acc

	function automatic logic [7:0] cw(input logic en, input logic [1:0] len, input logic [1:0] tol);
		return {2'b00, en, len, tol, 1'b0};
	endfunction : cw

	// restart the window by clearing enable, then stream the top n bits oldest first
	task automatic run(input logic [7:0] ctl, input logic [31:0] bits, input int n, input int ex);
		int base;
		acc(1'b1, SWD_IDX_CONTROL, 8'h00);
		acc(1'b1, SWD_IDX_CONTROL, ctl);
		base = n_found;
		for (int i = 31; i >= 32 - n; i--) begin
			rx_bit <= bits[i];
			rx_bit_valid <= 1'b1;
			@(posedge ref_clk);
		end
		rx_bit_valid <= 1'b0;
		repeat (4) @(posedge ref_clk);
		`CHK(n_found - base, ex)
	endtask : run

	task automatic final_report;
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : final_report

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		acc(1'b0, SWD_IDX_CONTROL, 8'h00);
		`CHK(rd, 32'h0000_0018)
		acc(1'b0, SWD_IDX_RESERVED, 8'h00);
		`CHK(rd, 32'h0000_0007)
		for (int b = 0; b < 4; b++) acc(1'b1, SWD_IDX_PATTERN0 + 8'(b), PAT[31-8*b -: 8]);
		acc(1'b0, SWD_IDX_PATTERN0, 8'h00);
		`CHK(rd, 32'h0000_00A5)
		acc(1'b1, SWD_IDX_CONTROL, 8'hFF);
		acc(1'b0, SWD_IDX_CONTROL, 8'h00);
		`CHK(rd, 32'h0000_003E)
		run(cw(1'b0, SWD_LEN_8, 2'h0), PAT, 8, 0);
		for (int c = 0; c < 4; c++) begin
			run(cw(1'b1, 2'(c), 2'h0), PAT, 8 * (c + 1), 1);
			run(cw(1'b1, 2'(c), 2'h0), PAT ^ 32'h8000_0000, 8 * (c + 1), 0);
		end
		// tolerance t: t flipped bits still match, t+1 do not
		for (int t = 0; t < 4; t++) begin
			run(cw(1'b1, SWD_LEN_8, 2'(t)), PAT ^ ~(32'hFFFF_FFFF >> t), 8, 1);
			run(cw(1'b1, SWD_LEN_8, 2'(t)), PAT ^ ~(32'hFFFF_FFFF >> (t + 1)), 8, 0);
		end
		rssi_in <= 8'hA5;
		repeat (3) @(posedge ref_clk);
		acc(1'b0, SWD_IDX_STRENGTH, 8'h00);
		`CHK(rd, 32'h0000_00A5)
		acc(1'b1, SWD_IDX_STRENGTH, 8'h3C);
		acc(1'b0, SWD_IDX_STRENGTH, 8'h00);
		`CHK(rd, 32'h0000_00A5)
		rssi_in <= 8'h5A;
		repeat (3) @(posedge ref_clk);
		acc(1'b0, SWD_IDX_STRENGTH, 8'h00);
		`CHK(rd, 32'h0000_005A)
		acc(1'b0, 8'h3F, 8'h00);
		`CHK(rd, SWD_UNMAPPED_DATA)
		// second reset in mid-run: control was left enabled with length 8, tolerance 3
		sys_rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(posedge ref_clk);
		acc(1'b0, SWD_IDX_CONTROL, 8'h00);
		`CHK(rd, 32'h0000_0018)
		acc(1'b0, SWD_IDX_PATTERN0, 8'h00);
		`CHK(rd, 32'h0000_0000)
		acc(1'b0, SWD_IDX_RESERVED, 8'h00);
		`CHK(rd, 32'h0000_0007)
		final_report();
	end

endmodule : testbench
